// ==== shared/dacwd_pkg.sv ====
// Constants, register map and types of the two-channel DAC word decoder.
// Assumes a 40 MHz system clock and a 32-bit Avalon-MM register port.

package dacwd_pkg;

   // ==========================================================
   // Geometry
   localparam int NCH      = 2;
   localparam int WORD_W   = 16;
   localparam int SP_W     = 12;
   localparam int MAG_W    = 11;
   localparam int SIGN_BIT = 15;
   localparam int ADDR_W   = 5;
   localparam int DATA_W   = 32;
   localparam int CNT_W    = 24;

   // ==========================================================
   // Register byte offsets
   localparam logic [ADDR_W-1:0] OFF_CH1_WORD = 5'h00;
   localparam logic [ADDR_W-1:0] OFF_CH2_WORD = 5'h04;
   localparam logic [ADDR_W-1:0] OFF_CTRL     = 5'h08;
   localparam logic [ADDR_W-1:0] OFF_STATUS   = 5'h0C;
   localparam logic [ADDR_W-1:0] OFF_SETPT    = 5'h10;

   // ==========================================================
   // Field positions and reset values
   localparam int CTRL_CUR_LSB   = 0;
   localparam int ST_BUSY_LSB    = 0;
   localparam int ST_NEGBLK_LSB  = 2;
   localparam int ST_SIGNERR_LSB = 4;
   localparam int ST_OVERRUN_LSB = 6;
   localparam int SETPT_CH2_LSB  = 16;
   localparam logic [NCH-1:0]    CTRL_RESET = 2'h0;
   localparam logic [WORD_W-1:0] WORD_RESET = 16'h0000;

   // ==========================================================
   // Timing
   localparam int CLK_PERIOD_NS = 25;
   localparam int CONV_TIME_NS  = 500000;
   localparam int SLOW_TIME_NS  = 1000000;
   localparam int CONV_CYC      = CONV_TIME_NS / CLK_PERIOD_NS;
   localparam int SLOW_CYC      = SLOW_TIME_NS / CLK_PERIOD_NS;

   // ==========================================================
   // Types
   typedef enum logic [1:0] {
      BUS_IDLE = 2'b01,
      BUS_ACK  = 2'b10
   } dacwd_bus_t;

endpackage

// ==== hw/dacwd_sync.sv ====
// Two-stage synchroniser for the negative-block jumper pins.
// Assumes the pins are static levels from outside the clock domain.
`timescale 1ns/1ps

module dacwd_sync (
   clk,
   srst,
   pin_in,
   pin_sync
);
   import dacwd_pkg::*;
   input  wire logic           clk;
   input  wire logic           srst;
   input  wire logic [NCH-1:0] pin_in;
   output      logic [NCH-1:0] pin_sync;

   logic [NCH-1:0] meta_reg;

   // ==========================================================
   // Synchroniser
   always_ff @(posedge clk) begin
      if (srst) begin
         meta_reg <= '0;
         pin_sync <= '0;
      end else begin
         meta_reg <= pin_in;
         pin_sync <= meta_reg;
      end
   end

endmodule

// ==== hw/dacwd_chan.sv ====
// Decoder of one channel's output word into a 12-bit DAC setpoint.
// Assumes load is a one-cycle pulse issued when a new word is stored.
`timescale 1ns/1ps

module dacwd_chan (
   clk,
   srst,
   load,
   code,
   neg_block,
   current_mode,
   setpoint,
   mode_out,
   load_out
);
   import dacwd_pkg::*;
   input  wire logic              clk;
   input  wire logic              srst;
   input  wire logic              load;
   input  wire logic [WORD_W-1:0] code;
   input  wire logic              neg_block;
   input  wire logic              current_mode;
   output      logic [SP_W-1:0]   setpoint;
   output      logic              mode_out;
   output      logic              load_out;

   // ==========================================================
   // Decode
   wire              sign_w  = code[SIGN_BIT];
   wire [SP_W-1:0]   volt_w  = {sign_w, code[MAG_W-1:0]};
   wire [SP_W-1:0]   curr_w  = {1'b0, code[MAG_W-1:0]};
   wire              zero_w  = sign_w & neg_block;
   wire [SP_W-1:0]   sp_next = current_mode ? curr_w :
                               (zero_w ? '0 : volt_w);

   // ==========================================================
   // Setpoint register, changed only by a load or a reset.
   always_ff @(posedge clk) begin
      if (srst) begin
         setpoint <= '0;
         mode_out <= 1'b0;
         load_out <= 1'b0;
      end else begin
         load_out <= load;
         if (load) begin
            setpoint <= sp_next;
            mode_out <= current_mode;
         end
      end
   end

endmodule

// ==== hw/dacwd_top.sv ====
// Top of the two-channel DAC word decoder with its Avalon-MM register port.
// Assumes one 40 MHz clock, synchronous reset, and static jumper pins.
//
// Local design decisions: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ps

module dacwd_top #(
   parameter int unsigned CONV_CYCLES = dacwd_pkg::CONV_CYC,
   parameter int unsigned SLOW_CYCLES = dacwd_pkg::SLOW_CYC
) (
   clk,
   srst,
   avs_address,
   avs_read,
   avs_write,
   avs_byteenable,
   avs_writedata,
   avs_readdata,
   avs_waitrequest,
   neg_block_select_ch1,
   neg_block_select_ch2,
   dac_setpoint_ch1,
   dac_setpoint_ch2,
   dac_current_mode,
   dac_load,
   conv_busy
);
   import dacwd_pkg::*;

   input  wire logic                        clk;
   input  wire logic                        srst;
   input  wire logic [dacwd_pkg::ADDR_W-1:0] avs_address;
   input  wire logic                        avs_read;
   input  wire logic                        avs_write;
   input  wire logic [3:0]                  avs_byteenable;
   input  wire logic [dacwd_pkg::DATA_W-1:0] avs_writedata;
   output      logic [dacwd_pkg::DATA_W-1:0] avs_readdata;
   output      logic                        avs_waitrequest;
   input  wire logic                        neg_block_select_ch1;
   input  wire logic                        neg_block_select_ch2;
   output      logic [dacwd_pkg::SP_W-1:0]   dac_setpoint_ch1;
   output      logic [dacwd_pkg::SP_W-1:0]   dac_setpoint_ch2;
   output      logic [dacwd_pkg::NCH-1:0]    dac_current_mode;
   output      logic [dacwd_pkg::NCH-1:0]    dac_load;
   output      logic [dacwd_pkg::NCH-1:0]    conv_busy;

   // ==========================================================
   // Timing counts
   localparam logic [CNT_W-1:0] CONV_LOAD = CNT_W'(CONV_CYCLES);
   localparam logic [CNT_W-1:0] SLOW_LOAD = CNT_W'(SLOW_CYCLES);

   // ==========================================================
   // Declarations
   dacwd_bus_t          bus_reg;
   dacwd_bus_t          bus_next;
   logic                waitreq_reg;
   logic [DATA_W-1:0]   rdata_reg;
   logic [NCH-1:0]      ctrl_reg;
   logic [NCH-1:0]      neg_blk_sync;
   logic [NCH-1:0]      start_reg;
   logic [NCH-1:0]      busy_reg;
   logic [NCH-1:0]      sign_err_reg;
   logic [NCH-1:0]      overrun_reg;
   logic [NCH-1:0][WORD_W-1:0] word_reg;
   logic [NCH-1:0][CNT_W-1:0]  cnt_reg;
   logic [NCH-1:0][SP_W-1:0]   setpt_w;
   logic [NCH-1:0]      mode_w;
   logic [NCH-1:0]      load_w;

   // ==========================================================
   // Jumper synchronisers
   dacwd_sync u_sync (
      .clk      (clk),
      .srst     (srst),
      .pin_in   ({neg_block_select_ch2, neg_block_select_ch1}),
      .pin_sync (neg_blk_sync)
   );

   // ==========================================================
   // Bus decode
   wire         req_w      = avs_read | avs_write;
   wire         take_w     = req_w & (bus_reg == BUS_ACK);
   wire         wr_take_w  = take_w & avs_write;
   wire [ADDR_W-1:0] addr_w = {avs_address[ADDR_W-1:2], 2'b00};
   wire         sel_ch1_w  = (addr_w == OFF_CH1_WORD);
   wire         sel_ch2_w  = (addr_w == OFF_CH2_WORD);
   wire         sel_ctrl_w = (addr_w == OFF_CTRL);
   wire         sel_stat_w = (addr_w == OFF_STATUS);
   wire         sel_setp_w = (addr_w == OFF_SETPT);
   wire [NCH-1:0] sel_ch_w = {sel_ch2_w, sel_ch1_w};
   wire [NCH-1:0] wr_ch_w  = {NCH{wr_take_w}} & sel_ch_w;
   wire         wr_ctrl_w  = wr_take_w & sel_ctrl_w;
   wire         wr_stat_w  = wr_take_w & sel_stat_w;
   wire [NCH-1:0] clr_sign_w =
      {NCH{wr_stat_w & avs_byteenable[0]}} &
      avs_writedata[ST_SIGNERR_LSB +: NCH];
   wire [NCH-1:0] clr_over_w =
      {NCH{wr_stat_w & avs_byteenable[0]}} &
      avs_writedata[ST_OVERRUN_LSB +: NCH];

   // ==========================================================
   // Read data selection
   wire [DATA_W-1:0] status_w = {
      24'h000000,
      overrun_reg,
      sign_err_reg,
      neg_blk_sync,
      busy_reg
   };
   wire [DATA_W-1:0] ctrl_rd_w  = {30'h00000000, ctrl_reg};
   wire [DATA_W-1:0] setpt_rd_w = {
      4'h0, setpt_w[1],
      4'h0, setpt_w[0]
   };
   wire [DATA_W-1:0] rd_mux_w =
      sel_ctrl_w ? ctrl_rd_w  :
      sel_stat_w ? status_w   :
      sel_setp_w ? setpt_rd_w :
      32'h00000000;

   // ==========================================================
   // Bus handshake: one wait cycle, then a one-cycle answer.
   always_comb begin
      case (bus_reg)
         BUS_IDLE: bus_next = req_w ? BUS_ACK : BUS_IDLE;
         BUS_ACK:  bus_next = BUS_IDLE;
         default:  bus_next = BUS_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         bus_reg     <= BUS_IDLE;
         waitreq_reg <= 1'b1;
      end else begin
         bus_reg     <= bus_next;
         waitreq_reg <= (bus_next != BUS_ACK);
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         rdata_reg <= 32'h00000000;
      end else if (bus_reg == BUS_IDLE && avs_read) begin
         rdata_reg <= rd_mux_w;
      end
   end

   assign avs_waitrequest = waitreq_reg;
   assign avs_readdata    = rdata_reg;

   // ==========================================================
   // Control register: per-channel current mode select.
   always_ff @(posedge clk) begin
      if (srst) begin
         ctrl_reg <= CTRL_RESET;
      end else if (wr_ctrl_w && avs_byteenable[0]) begin
         ctrl_reg <= avs_writedata[CTRL_CUR_LSB +: NCH];
      end
   end

   // ==========================================================
   // Per-channel word, conversion timer and sticky flags
   genvar ch;
   generate
      for (ch = 0; ch < NCH; ch = ch + 1) begin : g_ch
         wire [WORD_W-1:0] merged_w = {
            avs_byteenable[1] ? avs_writedata[15:8] : word_reg[ch][15:8],
            avs_byteenable[0] ? avs_writedata[7:0]  : word_reg[ch][7:0]
         };
         wire slow_w = ctrl_reg[ch] & merged_w[SIGN_BIT];
         wire [CNT_W-1:0] load_cnt_w = slow_w ? SLOW_LOAD : CONV_LOAD;

         always_ff @(posedge clk) begin
            if (srst) begin
               word_reg[ch]  <= WORD_RESET;
               start_reg[ch] <= 1'b0;
            end else begin
               start_reg[ch] <= wr_ch_w[ch];
               if (wr_ch_w[ch]) begin
                  word_reg[ch] <= merged_w;
               end
            end
         end

         // Busy spans the settle time; slow current words run longer.
         always_ff @(posedge clk) begin
            if (srst) begin
               cnt_reg[ch]  <= '0;
               busy_reg[ch] <= 1'b0;
            end else if (wr_ch_w[ch]) begin
               cnt_reg[ch]  <= load_cnt_w;
               busy_reg[ch] <= 1'b1;
            end else if (cnt_reg[ch] != '0) begin
               cnt_reg[ch]  <= cnt_reg[ch] - CNT_W'(1);
               busy_reg[ch] <= (cnt_reg[ch] != CNT_W'(1));
            end else begin
               busy_reg[ch] <= 1'b0;
            end
         end

         // Sticky flags: a new event wins over a clear in the same cycle.
         always_ff @(posedge clk) begin
            if (srst) begin
               sign_err_reg[ch] <= 1'b0;
               overrun_reg[ch]  <= 1'b0;
            end else begin
               if (wr_ch_w[ch] && slow_w) begin
                  sign_err_reg[ch] <= 1'b1;
               end else if (clr_sign_w[ch]) begin
                  sign_err_reg[ch] <= 1'b0;
               end
               if (wr_ch_w[ch] && busy_reg[ch]) begin
                  overrun_reg[ch] <= 1'b1;
               end else if (clr_over_w[ch]) begin
                  overrun_reg[ch] <= 1'b0;
               end
            end
         end

         dacwd_chan u_chan (
            .clk          (clk),
            .srst         (srst),
            .load         (start_reg[ch]),
            .code         (word_reg[ch]),
            .neg_block    (neg_blk_sync[ch]),
            .current_mode (ctrl_reg[ch]),
            .setpoint     (setpt_w[ch]),
            .mode_out     (mode_w[ch]),
            .load_out     (load_w[ch])
         );
      end
   endgenerate

   // ==========================================================
   // Outputs
   assign dac_setpoint_ch1 = setpt_w[0];
   assign dac_setpoint_ch2 = setpt_w[1];
   assign dac_current_mode = mode_w;
   assign dac_load         = load_w;
   assign conv_busy        = busy_reg;

endmodule

// ==== sim/dacwd_monitor.sv ====
// Concurrent checks on the ports of the DAC word decoder top.
// Assumes it is bound to dacwd_top with the same cycle parameters.
`timescale 1ns/1ps

module dacwd_monitor #(
   parameter int unsigned CONV_CYCLES = 8,
   parameter int unsigned SLOW_CYCLES = 16
) (
   input wire logic                         clk,
   input wire logic                         srst,
   input wire logic [dacwd_pkg::ADDR_W-1:0] avs_address,
   input wire logic                         avs_read,
   input wire logic                         avs_write,
   input wire logic [dacwd_pkg::DATA_W-1:0] avs_readdata,
   input wire logic                         avs_waitrequest,
   input wire logic [dacwd_pkg::SP_W-1:0]   dac_setpoint_ch1,
   input wire logic [dacwd_pkg::SP_W-1:0]   dac_setpoint_ch2,
   input wire logic [dacwd_pkg::NCH-1:0]    dac_current_mode,
   input wire logic [dacwd_pkg::NCH-1:0]    dac_load,
   input wire logic [dacwd_pkg::NCH-1:0]    conv_busy
);
   import dacwd_pkg::*;
   logic [23:0] busy_cnt_reg;

   default clocking @(posedge clk); endclocking
   default disable iff (srst);

   // Counts the cycles of the current busy stretch of channel one.
   always_ff @(posedge clk) begin
      if (srst || !conv_busy[0]) busy_cnt_reg <= 24'h000000;
      else busy_cnt_reg <= busy_cnt_reg + 24'h000001;
   end

   sequence s_acc1;
      avs_write && !avs_waitrequest && avs_address == OFF_CH1_WORD;
   endsequence
   sequence s_acc2;
      avs_write && !avs_waitrequest && avs_address == OFF_CH2_WORD;
   endsequence

   property p_ack;
      (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
   endproperty
   property p_wait_one;
      !avs_waitrequest |=> avs_waitrequest;
   endproperty
   property p_ch1_seq;
      s_acc1 |-> ##1 conv_busy[0] ##1 (dac_load[0] && conv_busy[0]);
   endproperty
   property p_ch2_seq;
      s_acc2 |-> ##1 conv_busy[1] ##1 (dac_load[1] && conv_busy[1]);
   endproperty
   property p_hold1;
      !$stable(dac_setpoint_ch1) |-> dac_load[0];
   endproperty
   property p_hold2;
      !$stable(dac_setpoint_ch2) |-> dac_load[1];
   endproperty
   property p_cur_pos;
      dac_load[0] && dac_current_mode[0] |-> dac_setpoint_ch1[11] == 1'b0;
   endproperty
   property p_cur_pos2;
      dac_load[1] && dac_current_mode[1] |-> dac_setpoint_ch2[11] == 1'b0;
   endproperty
   property p_busy_len;
      $fell(conv_busy[0]) |->
         busy_cnt_reg == 24'(CONV_CYCLES) || busy_cnt_reg == 24'(SLOW_CYCLES);
   endproperty
   property p_rd_wo;
      avs_read && !avs_waitrequest && avs_address == OFF_CH1_WORD |-> avs_readdata == '0;
   endproperty

   a_ack: assert property (p_ack) else $error("request not answered next cycle");
   a_wait_one: assert property (p_wait_one) else $error("waitrequest low too long");
   a_ch1_seq: assert property (p_ch1_seq) else $error("channel one load late");
   a_ch2_seq: assert property (p_ch2_seq) else $error("channel two load late");
   a_hold1: assert property (p_hold1) else $error("channel one moved unloaded");
   a_hold2: assert property (p_hold2) else $error("channel two moved unloaded");
   a_cur_pos: assert property (p_cur_pos) else $error("current setpoint negative");
   a_cur_pos2: assert property (p_cur_pos2) else $error("current setpoint two negative");
   a_busy_len: assert property (p_busy_len) else $error("busy length wrong");
   a_rd_wo: assert property (p_rd_wo) else $error("output word readable");
endmodule

// ==== sim/dacwd_host.sv ====
// Host model: a controller CPU writing output words over Avalon-MM.
// Assumes its tasks are called just after a rising clock edge.
`timescale 1ns/1ps

module dacwd_host (
   input  wire logic                         clk,
   output      logic [dacwd_pkg::ADDR_W-1:0] avs_address,
   output      logic                         avs_read,
   output      logic                         avs_write,
   output      logic [3:0]                   avs_byteenable,
   output      logic [dacwd_pkg::DATA_W-1:0] avs_writedata,
   input  wire logic [dacwd_pkg::DATA_W-1:0] avs_readdata,
   input  wire logic                         avs_waitrequest
);
   import dacwd_pkg::*;

   initial begin
      avs_address    <= '0;
      avs_read       <= 1'b0;
      avs_write      <= 1'b0;
      avs_byteenable <= 4'hF;
      avs_writedata  <= '0;
   end

   // Words are sign and magnitude; bit 15 is set on a current channel only on purpose.
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge clk);
      avs_address   <= a;
      avs_writedata <= d;
      avs_write     <= 1'b1;
      do @(posedge clk); while (avs_waitrequest !== 1'b0);
      avs_write     <= 1'b0;
      avs_writedata <= ~d;
   endtask

   task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
      @(posedge clk);
      avs_address <= a;
      avs_read    <= 1'b1;
      do @(posedge clk); while (avs_waitrequest !== 1'b0);
      d = avs_readdata;
      avs_read <= 1'b0;
   endtask
endmodule

// ==== sim/test_dual_channel_dac_word_decoder.sv ====
// Self-checking bench of the DAC word decoder with a host model on its bus.
// Assumes short busy counts of 8 and 16 cycles.
`timescale 1ns/1ps

module test_dual_channel_dac_word_decoder;
   import dacwd_pkg::*;
   localparam int unsigned CONV = 8;
   localparam int unsigned SLOW = 16;
   // Flags per case: channel two, current mode, block one, block two.
   localparam logic [3:0] FLAGS [13] = '{4'h0, 4'h0, 4'h0, 4'h8, 4'h0, 4'h2, 4'hA, 4'h9,
      4'h2, 4'h4, 4'h4, 4'h4, 4'hC};
   localparam logic [15:0] CODES [13] = '{16'h0000, 16'h07FF, 16'hF800, 16'hFFFF, 16'h7800,
      16'hFFFF, 16'hF800, 16'hF800, 16'h07FF, 16'h07FF, 16'h7800, 16'h8001, 16'h0400};
   logic              clk = 1'b0;
   logic              srst = 1'b1;
   logic              blk1 = 1'b0;
   logic              blk2 = 1'b0;
   logic [ADDR_W-1:0] avs_address;
   logic              avs_read, avs_write, avs_waitrequest;
   logic [3:0]        avs_byteenable;
   logic [DATA_W-1:0] avs_writedata, avs_readdata, rdata;
   logic [SP_W-1:0]   dac_setpoint_ch1, dac_setpoint_ch2;
   logic [NCH-1:0]    dac_current_mode, dac_load, conv_busy;
   logic [SP_W-1:0]   exp_sp [2];
   logic [3:0]        f;
   int                n;
   int                num_errors = 0;
   int                checked = 0;

   always #12.5 clk = ~clk;

   dacwd_host dacwd_host_i (.clk(clk), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

   dacwd_top #(.CONV_CYCLES(CONV), .SLOW_CYCLES(SLOW)) dacwd_top_i (.clk(clk), .srst(srst),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .neg_block_select_ch1(blk1), .neg_block_select_ch2(blk2),
      .dac_setpoint_ch1(dac_setpoint_ch1), .dac_setpoint_ch2(dac_setpoint_ch2),
      .dac_current_mode(dac_current_mode), .dac_load(dac_load), .conv_busy(conv_busy));

   function automatic logic [SP_W-1:0] expect_sp(logic [15:0] c, logic b, logic cu);
      if (cu) return {1'b0, c[10:0]};
      if (c[15] && b) return 12'h000;
      return {c[15], c[10:0]};
   endfunction

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic close_out;
      $display("Comparisons %0d, mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge clk);
      num_errors++;
      close_out();
   end

   initial begin
      exp_sp[0] = 12'h000;
      exp_sp[1] = 12'h000;
      repeat (16) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      check(32'({dac_setpoint_ch2, dac_setpoint_ch1, dac_current_mode, conv_busy}), 0);
      // Blocked channels see negative codes to prove the zero clamp, and in case 8 a positive code.
      for (int i = 0; i < 13; i++) begin
         f = FLAGS[i];
         blk1 <= f[1];
         blk2 <= f[0];
         dacwd_host_i.wr(OFF_CTRL, {30'h0, f[2] & f[3], f[2] & !f[3]});
         dacwd_host_i.wr(f[3] ? OFF_CH2_WORD : OFF_CH1_WORD, {16'h0, CODES[i]});
         exp_sp[f[3]] = expect_sp(CODES[i], f[3] ? f[0] : f[1], f[2]);
         n = 0;
         // Waiting out the settle time before the next write.
         repeat (40) begin
            @(posedge clk);
            n += (conv_busy[f[3]] === 1'b1);
         end
         check(32'(n), 32'((f[2] && CODES[i][15]) ? SLOW : CONV));
         check(32'(dac_setpoint_ch1), 32'(exp_sp[0]));
         check(32'(dac_setpoint_ch2), 32'(exp_sp[1]));
         check(32'(dac_current_mode[f[3]]), 32'(f[2]));
      end
      dacwd_host_i.rd(OFF_SETPT, rdata);
      check(rdata, {4'h0, exp_sp[1], 4'h0, exp_sp[0]});
      dacwd_host_i.rd(OFF_CH2_WORD, rdata);
      check(rdata, 32'h00000000);
      dacwd_host_i.rd(OFF_CH1_WORD, rdata);
      check(rdata, 32'h00000000);
      // Only the slow current word of case 11 leaves a sticky flag behind.
      dacwd_host_i.rd(OFF_STATUS, rdata);
      check(rdata, 32'h00000001 << ST_SIGNERR_LSB);
      dacwd_host_i.wr(OFF_STATUS, 32'h00000001 << ST_SIGNERR_LSB);
      dacwd_host_i.rd(OFF_STATUS, rdata);
      check(rdata, 32'h00000000);
      dacwd_host_i.wr(5'h14, 32'hFFFFFFFF);
      dacwd_host_i.rd(5'h14, rdata);
      check(rdata, 32'h00000000);
      // A second reset in mid-run clears both setpoints and the latched modes.
      srst <= 1'b1;
      repeat (3) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      check(32'({dac_setpoint_ch2, dac_setpoint_ch1, dac_current_mode, conv_busy}), 0);
      close_out();
   end
endmodule

bind dacwd_top dacwd_monitor #(.CONV_CYCLES(CONV_CYCLES), .SLOW_CYCLES(SLOW_CYCLES))
   dacwd_monitor_i (.clk(clk), .srst(srst), .avs_address(avs_address),
   .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .dac_setpoint_ch1(dac_setpoint_ch1),
   .dac_setpoint_ch2(dac_setpoint_ch2), .dac_current_mode(dac_current_mode),
   .dac_load(dac_load), .conv_busy(conv_busy));
